// ===== stxe_pkg.sv
// package for the skip, table-read and xor execution unit
// assumes one clock domain; all users write stxe_pkg::name
package stxe_pkg;
  // data memory address width
  localparam int DAW = 12;
  // program memory address width
  localparam int PAW = 16;
  // program word width
  localparam int PWW = 16;
  // page bits above the low pointer
  localparam int PGW = PAW - 8;
  // all-ones page selects the last page
  localparam logic [PGW-1:0] LAST_PAGE = {PGW{1'b1}};
  // register bus address width
  localparam int RAW = 4;
  // register offsets
  localparam logic [RAW-1:0] REG_ACCUM = 4'h0;
  localparam logic [RAW-1:0] REG_TPL = 4'h1;
  localparam logic [RAW-1:0] REG_TPH = 4'h2;
  localparam logic [RAW-1:0] REG_THB = 4'h3;
  localparam logic [RAW-1:0] REG_STAT = 4'h4;
  // status field positions
  localparam int STAT_Z = 0;
  localparam int STAT_BUSY = 1;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // instruction codes
  typedef enum logic [3:0] {
    OP_SZ = 4'h0,
    OP_SZA = 4'h1,
    OP_SZB = 4'h2,
    OP_TRS = 4'h3,
    OP_TRL = 4'h4,
    OP_ITRS = 4'h5,
    OP_ITRL = 4'h6,
    OP_XA = 4'h7,
    OP_XM = 4'h8
  } stxe_op_t;
  // execution states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_EXEC = 2'b10,
    ST_DUMMY = 2'b11
  } stxe_state_t;
  // instruction issue
  typedef struct packed {
    logic valid;
    stxe_op_t op;
    logic [DAW-1:0] addr;
    logic [2:0] bit_sel;
  } stxe_cmd_t;
  // completion report
  typedef struct packed {
    logic done;
    logic skip;
  } stxe_done_t;
  // data memory request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [DAW-1:0] addr;
    logic [7:0] wdata;
  } stxe_dreq_t;
endpackage

// ===== stxe_rst_sync.sv
// reset release synchroniser
// assumes rst_n is asynchronous to mclk
`timescale 1ns/1ps
module stxe_rst_sync (
  input wire logic mclk,
  input wire logic rst_n,
  output logic rst_sync_n
);
  // first stage, read only by the second
  logic meta_r;
  // two-stage release, assert at once
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      meta_r <= 1'b1;
      rst_sync_n <= meta_r;
    end
  end
endmodule

// ===== stxe_alu.sv
// combinational datapath: skip test, xor, zero, result byte
// assumes operands are stable during the execute state
`timescale 1ns/1ps
module stxe_alu (
  input wire stxe_pkg::stxe_op_t op,
  input wire logic [7:0] accum,
  input wire logic [7:0] mem,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] pword_lo,
  output logic [7:0] res,
  output logic skip,
  output logic zero
);
  // xor of accumulator and memory byte
  logic [7:0] x;
  assign x = accum ^ mem;
  assign zero = (x == 8'h00);
  // result byte and skip decision per op
  always_comb begin
    res = mem;
    skip = 1'b0;
    case (op)
      stxe_pkg::OP_SZ, stxe_pkg::OP_SZA: begin
        skip = (mem == 8'h00);
      end
      stxe_pkg::OP_SZB: begin
        skip = ~mem[bit_sel];
      end
      stxe_pkg::OP_TRS, stxe_pkg::OP_TRL,
      stxe_pkg::OP_ITRS, stxe_pkg::OP_ITRL: begin
        res = pword_lo;
      end
      stxe_pkg::OP_XA, stxe_pkg::OP_XM: begin
        res = x;
      end
      default: begin
        res = mem;
      end
    endcase
  end
endmodule

// ===== stxe_core.sv
// execution unit for zero skips, table reads and xor
// assumes one-cycle read latency on data and program memory
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module stxe_core (
  input wire logic mclk,
  input wire logic rst_n,
  input wire stxe_pkg::stxe_cmd_t cmd,
  output logic cmd_ready_r,
  output stxe_pkg::stxe_done_t done_r,
  output stxe_pkg::stxe_dreq_t dreq_r,
  input wire logic [7:0] dmem_rdata,
  output logic pmem_rd_r,
  output logic [stxe_pkg::PAW-1:0] pmem_addr_r,
  input wire logic [stxe_pkg::PWW-1:0] pmem_rdata,
  input wire logic [stxe_pkg::RAW-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_r
);
  // op is one of the table reads
  function automatic logic is_table(input stxe_pkg::stxe_op_t op);
    is_table = (op == stxe_pkg::OP_TRS) || (op == stxe_pkg::OP_TRL) ||
               (op == stxe_pkg::OP_ITRS) || (op == stxe_pkg::OP_ITRL);
  endfunction

  // op pre-increments the low pointer
  function automatic logic is_incr(input stxe_pkg::stxe_op_t op);
    is_incr = (op == stxe_pkg::OP_ITRS) || (op == stxe_pkg::OP_ITRL);
  endfunction

  // op reads the last page
  function automatic logic is_last(input stxe_pkg::stxe_op_t op);
    is_last = (op == stxe_pkg::OP_TRL) || (op == stxe_pkg::OP_ITRL);
  endfunction

  // op writes data memory at execute
  function automatic logic is_mwr(input stxe_pkg::stxe_op_t op);
    is_mwr = (op == stxe_pkg::OP_SZ) || (op == stxe_pkg::OP_XM) || is_table(op);
  endfunction

  // op writes the accumulator
  function automatic logic is_awr(input stxe_pkg::stxe_op_t op);
    is_awr = (op == stxe_pkg::OP_SZA) || (op == stxe_pkg::OP_XA);
  endfunction

  // op updates the zero flag
  function automatic logic is_xor(input stxe_pkg::stxe_op_t op);
    is_xor = (op == stxe_pkg::OP_XA) || (op == stxe_pkg::OP_XM);
  endfunction

  // synchronised reset
  logic rst_sync_n;
  // state and its next value
  stxe_pkg::stxe_state_t state_r;
  stxe_pkg::stxe_state_t state_nxt;
  // latched instruction fields
  stxe_pkg::stxe_op_t op_r;
  logic [2:0] bit_r;
  // programmer-visible registers
  logic [7:0] accum_r;
  logic z_r;
  logic [7:0] tpl_r;
  logic [7:0] tph_r;
  logic [7:0] thb_r;
  // accept strobe
  logic go;
  // low pointer seen by the read
  logic [7:0] tpl_use;
  // datapath outputs
  logic [7:0] alu_res;
  logic alu_skip;
  logic alu_zero;
  // execute-cycle and accept-cycle update strobes
  logic ex;
  logic ex_awr;
  logic ex_zwr;
  logic go_inc;

  // reset release
  stxe_rst_sync u_rst (
    .mclk(mclk),
    .rst_n(rst_n),
    .rst_sync_n(rst_sync_n)
  );

  // skip test, xor and result byte
  stxe_alu u_alu (
    .op(op_r),
    .accum(accum_r),
    .mem(dmem_rdata),
    .bit_sel(bit_r),
    .pword_lo(pmem_rdata[7:0]),
    .res(alu_res),
    .skip(alu_skip),
    .zero(alu_zero)
  );

  assign go = cmd.valid && cmd_ready_r;
  assign ex = (state_r == stxe_pkg::ST_EXEC);
  assign ex_awr = ex && is_awr(op_r);
  assign ex_zwr = ex && is_xor(op_r);
  assign go_inc = go && is_incr(cmd.op);
  assign tpl_use = go_inc ? 8'(tpl_r + 8'h01) : tpl_r;

  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      stxe_pkg::ST_IDLE: begin
        if (go) begin
          state_nxt = stxe_pkg::ST_FETCH;
        end
      end
      stxe_pkg::ST_FETCH: begin
        state_nxt = stxe_pkg::ST_EXEC;
      end
      stxe_pkg::ST_EXEC: begin
        // dummy cycle only on a taken skip
        // untaken skip returns straight to idle
        state_nxt = alu_skip ? stxe_pkg::ST_DUMMY : stxe_pkg::ST_IDLE;
      end
      stxe_pkg::ST_DUMMY: begin
        state_nxt = stxe_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = stxe_pkg::ST_IDLE;
      end
    endcase
  end

  // state register and ready
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_r <= stxe_pkg::ST_IDLE;
      cmd_ready_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cmd_ready_r <= (state_nxt == stxe_pkg::ST_IDLE);
    end
  end

  // latch the instruction on accept
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      op_r <= stxe_pkg::OP_SZ;
      bit_r <= 3'h0;
    end else if (go) begin
      op_r <= cmd.op;
      bit_r <= cmd.bit_sel;
    end
  end

  // data memory request
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dreq_r <= '0;
    end else begin
      dreq_r.rd <= go && !is_table(cmd.op);
      dreq_r.wr <= ex && is_mwr(op_r);
      if (go) begin
        dreq_r.addr <= cmd.addr;
      end
      if (ex) begin
        dreq_r.wdata <= alu_res;
      end
    end
  end

  // program memory request
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pmem_rd_r <= 1'b0;
      pmem_addr_r <= '0;
    end else begin
      pmem_rd_r <= go && is_table(cmd.op);
      if (go && is_table(cmd.op)) begin
        if (is_last(cmd.op)) begin
          pmem_addr_r <= {stxe_pkg::LAST_PAGE, tpl_use};
        end else begin
          pmem_addr_r <= {tph_r[stxe_pkg::PGW-1:0], tpl_use};
        end
      end
    end
  end

  // completion report
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      done_r <= '0;
    end else begin
      done_r.done <= ex;
      done_r.skip <= ex && alu_skip;
    end
  end

  // accumulator: instruction wins over software
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      accum_r <= stxe_pkg::RST_BYTE;
    end else if (ex_awr) begin
      accum_r <= (op_r == stxe_pkg::OP_SZA) ? dmem_rdata : alu_res;
    end else if (reg_wr && reg_addr == stxe_pkg::REG_ACCUM) begin
      accum_r <= reg_wdata;
    end
  end

  // zero flag
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      z_r <= 1'b0;
    end else if (ex_zwr) begin
      z_r <= alu_zero;
    end else if (reg_wr && reg_addr == stxe_pkg::REG_STAT) begin
      z_r <= reg_wdata[stxe_pkg::STAT_Z];
    end
  end

  // table pointers
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tpl_r <= stxe_pkg::RST_BYTE;
      tph_r <= stxe_pkg::RST_BYTE;
    end else begin
      if (go_inc) begin
        tpl_r <= tpl_use;
      end else if (reg_wr && reg_addr == stxe_pkg::REG_TPL) begin
        tpl_r <= reg_wdata;
      end
      if (reg_wr && reg_addr == stxe_pkg::REG_TPH) begin
        tph_r <= reg_wdata;
      end
    end
  end

  // table high byte
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      thb_r <= stxe_pkg::RST_BYTE;
    end else if (ex && is_table(op_r)) begin
      thb_r <= pmem_rdata[15:8];
    end else if (reg_wr && reg_addr == stxe_pkg::REG_THB) begin
      thb_r <= reg_wdata;
    end
  end

  // register read, data in the next cycle only
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        stxe_pkg::REG_ACCUM: reg_rdata_r <= accum_r;
        stxe_pkg::REG_TPL: reg_rdata_r <= tpl_r;
        stxe_pkg::REG_TPH: reg_rdata_r <= tph_r;
        stxe_pkg::REG_THB: reg_rdata_r <= thb_r;
        stxe_pkg::REG_STAT: begin
          reg_rdata_r <= {6'h00, (state_r != stxe_pkg::ST_IDLE), z_r};
        end
        default: reg_rdata_r <= 8'h00;
      endcase
    end else begin
      reg_rdata_r <= 8'h00;
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_sync_n);

  // execute step of each op
  sequence ex_of(stxe_pkg::stxe_op_t o);
    ex && op_r == o;
  endsequence

  // accepted instruction reaching a taken skip
  sequence taken_skip;
    go ##3 (done_r.done && done_r.skip);
  endsequence

  skip_zero_a: assert property (ex_of(stxe_pkg::OP_SZ) |=>
    dreq_r.wr && dreq_r.wdata == $past(dmem_rdata) &&
    done_r.skip == ($past(dmem_rdata) == 8'h00))
    else $error("zero skip wrong");

  // three cycles on a taken skip
  skip_len_a: assert property (taken_skip |->
    !cmd_ready_r ##1 cmd_ready_r)
    else $error("taken skip not three cycles");

  move_accum_a: assert property (ex_of(stxe_pkg::OP_SZA) |=>
    accum_r == $past(dmem_rdata) && done_r.skip == (accum_r == 8'h00))
    else $error("copy skip wrong");

  bit_clr_a: assert property (ex_of(stxe_pkg::OP_SZB) |=>
    done_r.skip == !$past(dmem_rdata[bit_r]))
    else $error("bit skip wrong");

  tbl_spec_a: assert property (go && cmd.op == stxe_pkg::OP_TRS |=>
    pmem_rd_r && pmem_addr_r == {$past(tph_r[stxe_pkg::PGW-1:0]), $past(tpl_r)})
    else $error("specific page address wrong");

  tbl_last_a: assert property (go && cmd.op == stxe_pkg::OP_TRL |=>
    pmem_rd_r && pmem_addr_r == {stxe_pkg::LAST_PAGE, $past(tpl_r)})
    else $error("last page address wrong");

  tbl_incr_a: assert property (go_inc |=>
    tpl_r == $past(tpl_r) + 8'h01 && pmem_addr_r[7:0] == tpl_r)
    else $error("pointer not incremented first");

  tbl_dest_a: assert property (ex && is_table(op_r) |=>
    dreq_r.wr && dreq_r.wdata == $past(pmem_rdata[7:0]) &&
    thb_r == $past(pmem_rdata[15:8]))
    else $error("table bytes misplaced");

  xor_accum_a: assert property (ex_of(stxe_pkg::OP_XA) |=>
    accum_r == ($past(accum_r) ^ $past(dmem_rdata)) && z_r == (accum_r == 8'h00) && !dreq_r.wr)
    else $error("accumulator xor wrong");

  xor_mem_a: assert property (ex_of(stxe_pkg::OP_XM) |=>
    dreq_r.wr && dreq_r.wdata == ($past(accum_r) ^ $past(dmem_rdata)) &&
    z_r == (dreq_r.wdata == 8'h00))
    else $error("memory xor wrong");

  // untaken skip ends at once, flags kept
  no_dummy_a: assert property (ex && !is_xor(op_r) && !reg_wr |=>
    z_r == $past(z_r) && (done_r.skip || cmd_ready_r))
    else $error("flag changed or dummy inserted");
endmodule

// ===== stxe_mem_model.sv
// memory model: data bytes and program words beside the execution unit
// assumes one-cycle read latency and requests sampled at the rising edge
`timescale 1ns/1ps
module stxe_mem_model (
  input wire logic mclk,
  input wire stxe_pkg::stxe_dreq_t dreq,
  output logic [7:0] dmem_rdata,
  input wire logic pmem_rd,
  input wire logic [stxe_pkg::PAW-1:0] pmem_addr,
  output logic [stxe_pkg::PWW-1:0] pmem_rdata
);
  // data bytes, loaded by the bench
  logic [7:0] mem [0:4095];
  // program word made from its address, halves differ to catch swaps
  function automatic logic [15:0] pword(input logic [15:0] a);
    return {a[7:0] ^ 8'h3C, a[15:8] ^ 8'hA5};
  endfunction
  // idle values before the first request
  initial begin
    dmem_rdata = 8'hA5;
    pmem_rdata = 16'h5AC3;
  end
  // data port: write, one-cycle read, idle data toggles
  always @(posedge mclk) begin
    if (dreq.wr) begin
      mem[dreq.addr] <= dreq.wdata;
    end
    if (dreq.rd) begin
      dmem_rdata <= mem[dreq.addr];
    end else begin
      dmem_rdata <= ~dmem_rdata;
    end
  end
  // program port: one-cycle read, idle word toggles
  always @(posedge mclk) begin
    if (pmem_rd) begin
      pmem_rdata <= pword(pmem_addr);
    end else begin
      pmem_rdata <= ~pmem_rdata;
    end
  end
endmodule

// ===== tb.sv
// self-checking bench for the skip, table-read and xor unit
// assumes the memory model answers one cycle after each request
`timescale 1ns/1ps
module tb;
  // expected outcome of one instruction
  typedef struct packed {
    logic skip;
    logic wr;
    logic chkp;
    logic [11:0] addr;
    logic [7:0] wdata;
    logic [15:0] paddr;
  } stxe_note_t;
  logic mclk;
  logic rst_n;
  stxe_pkg::stxe_cmd_t cmd;
  logic cmd_ready_r;
  stxe_pkg::stxe_done_t done_r;
  stxe_pkg::stxe_dreq_t dreq_r;
  logic [7:0] dmem_rdata;
  logic pmem_rd_r;
  logic [15:0] pmem_addr_r;
  logic [15:0] pmem_rdata;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata_r;
  // shadow state of memory and registers
  logic [7:0] sh [0:4095];
  logic [7:0] accum_m;
  logic [7:0] tpl_m;
  logic [7:0] tph_m;
  logic [7:0] thb_m;
  logic z_m;
  logic rd_d;
  logic [31:0] lf;
  int fails;
  int n_checks;
  stxe_note_t nq [$];
  logic [7:0] rq [$];
  stxe_core u_dut (.mclk(mclk), .rst_n(rst_n), .cmd(cmd), .cmd_ready_r(cmd_ready_r),
    .done_r(done_r), .dreq_r(dreq_r), .dmem_rdata(dmem_rdata), .pmem_rd_r(pmem_rd_r),
    .pmem_addr_r(pmem_addr_r), .pmem_rdata(pmem_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r));
  stxe_mem_model u_mem (.mclk(mclk), .dreq(dreq_r), .dmem_rdata(dmem_rdata),
    .pmem_rd(pmem_rd_r), .pmem_addr(pmem_addr_r), .pmem_rdata(pmem_rdata));
  // free-running clock, 4 ns
  always #2 mclk = ~mclk;
  // lfsr step
  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction
  // expected program word
  function automatic logic [15:0] pw(input logic [15:0] a);
    return {a[7:0] ^ 8'h3C, a[15:8] ^ 8'hA5};
  endfunction
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task print_verdict;
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // count low-ready cycles at falling edges, bounded
  task wait_ready(output int k);
    k = 0;
    @(negedge mclk);
    while (cmd_ready_r !== 1'b1 && k < 20) begin
      @(negedge mclk);
      k++;
    end
    if (k == 20) begin
      fails++;
      print_verdict();
    end
  endtask
  // register write, shadow follows
  task reg_write(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    case (a)
      stxe_pkg::REG_ACCUM: accum_m = d;
      stxe_pkg::REG_TPL: tpl_m = d;
      stxe_pkg::REG_TPH: tph_m = d;
      stxe_pkg::REG_THB: thb_m = d;
      stxe_pkg::REG_STAT: z_m = d[stxe_pkg::STAT_Z];
      default: ;
    endcase
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  // register read, expectation queued
  task reg_read(input logic [3:0] a, input logic [7:0] e);
    rq.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
  endtask
  // read back every mapped register
  task rd_all;
    reg_read(stxe_pkg::REG_ACCUM, accum_m);
    reg_read(stxe_pkg::REG_TPL, tpl_m);
    reg_read(stxe_pkg::REG_TPH, tph_m);
    reg_read(stxe_pkg::REG_THB, thb_m);
    reg_read(stxe_pkg::REG_STAT, {7'h00, z_m});
  endtask
  // predict, issue and time one instruction
  task issue(input stxe_pkg::stxe_op_t op, input logic [11:0] a, input logic [2:0] b);
    stxe_note_t n;
    logic [7:0] v;
    logic [15:0] w;
    int k;
    n = '0;
    v = sh[a];
    case (op)
      stxe_pkg::OP_SZ: begin
        n.skip = (v == 8'h00);
        n.wr = 1'b1;
        n.wdata = v;
      end
      stxe_pkg::OP_SZA: begin
        accum_m = v;
        n.skip = (v == 8'h00);
      end
      stxe_pkg::OP_SZB: n.skip = ~v[b];
      stxe_pkg::OP_XA: begin
        accum_m = accum_m ^ v;
        z_m = (accum_m == 8'h00);
      end
      stxe_pkg::OP_XM: begin
        n.wr = 1'b1;
        n.wdata = accum_m ^ v;
        z_m = (n.wdata == 8'h00);
      end
      stxe_pkg::OP_TRS, stxe_pkg::OP_TRL, stxe_pkg::OP_ITRS, stxe_pkg::OP_ITRL: begin
        if (op == stxe_pkg::OP_ITRS || op == stxe_pkg::OP_ITRL) tpl_m = tpl_m + 8'h01;
        n.paddr[15:8] = (op == stxe_pkg::OP_TRS || op == stxe_pkg::OP_ITRS) ?
          tph_m : stxe_pkg::LAST_PAGE;
        n.paddr[7:0] = tpl_m;
        w = pw(n.paddr);
        n.chkp = 1'b1;
        n.wr = 1'b1;
        n.wdata = w[7:0];
        thb_m = w[15:8];
      end
      default: ;
    endcase
    if (n.wr) sh[a] = n.wdata;
    n.addr = a;
    nq.push_back(n);
    cmd <= {1'b1, op, a, b};
    wait_ready(k);
    @(posedge mclk);
    cmd <= '0;
    wait_ready(k);
    chk(k, 2 + n.skip);
    @(posedge mclk);
  endtask
  // read strobe delayed to the answer cycle
  always @(posedge mclk) rd_d <= reg_rd;
  // monitor: completions and register answers against the queues
  always @(negedge mclk) begin
    stxe_note_t nt;
    if (done_r.done === 1'b1) begin
      if (nq.size() == 0) chk(32'h1, 32'h0);
      else begin
        nt = nq.pop_front();
        chk(done_r.skip, nt.skip);
        chk(dreq_r.wr, nt.wr);
        if (nt.wr) chk({dreq_r.addr, dreq_r.wdata}, {nt.addr, nt.wdata});
        if (nt.chkp) chk(pmem_addr_r, nt.paddr);
      end
    end
    if (rd_d === 1'b1) chk(reg_rdata_r, (rq.size() > 0) ? rq.pop_front() : 8'hXX);
    else chk(reg_rdata_r, 8'h00);
  end
  // main sequence
  initial begin
    logic [31:0] r;
    int k;
    mclk = 1'b0;
    rst_n = 1'b0;
    cmd = '0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    lf = 32'hD1C3;
    fails = 0;
    n_checks = 0;
    {accum_m, tpl_m, tph_m, thb_m, z_m} = '0;
    // every fourth byte zero so skips are taken often
    for (int i = 0; i < 4096; i++) begin
      r = rnd();
      sh[i] = (i % 4 == 0) ? 8'h00 : r[7:0];
      u_mem.mem[i] = sh[i];
    end
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    // reset values, unmapped read
    rd_all();
    reg_read(4'hF, 8'h00);
    // busy bit read-only, zero flag writable
    reg_write(stxe_pkg::REG_STAT, 8'hFF);
    reg_write(4'h9, 8'h77);
    reg_read(4'h9, 8'h00);
    issue(stxe_pkg::OP_SZ, 12'h000, 3'h0);
    issue(stxe_pkg::OP_SZ, 12'h001, 3'h0);
    issue(stxe_pkg::OP_SZA, 12'h004, 3'h0);
    issue(stxe_pkg::OP_SZA, 12'h001, 3'h0);
    for (int i = 0; i < 8; i++) issue(stxe_pkg::OP_SZB, 12'h003, i[2:0]);
    rd_all();
    // table reads across the pointer wrap
    reg_write(stxe_pkg::REG_TPL, 8'hFE);
    reg_write(stxe_pkg::REG_TPH, 8'h12);
    for (int i = 0; i < 4; i++) begin
      issue(stxe_pkg::stxe_op_t'(4'h3 + i[3:0]), 12'h006 + i[11:0], 3'h0);
      rd_all();
    end
    // xor to zero result, then xor into memory
    reg_write(stxe_pkg::REG_STAT, 8'h00);
    reg_write(stxe_pkg::REG_ACCUM, sh[5]);
    issue(stxe_pkg::OP_XA, 12'h005, 3'h0);
    rd_all();
    reg_write(stxe_pkg::REG_ACCUM, 8'h5A);
    issue(stxe_pkg::OP_XM, 12'h006, 3'h0);
    issue(stxe_pkg::OP_SZ, 12'h006, 3'h0);
    rd_all();
    // random mix over a small address range
    for (int i = 0; i < 60; i++) begin
      r = rnd();
      issue(stxe_pkg::stxe_op_t'(r[3:0] % 4'h9), {8'h00, r[7:4]}, r[10:8]);
      if (r[12]) reg_write(r[15:13] % 3'h5, r[23:16]);
      rd_all();
    end
    repeat (5) @(posedge mclk);
    chk(nq.size(), 0);
    chk(rq.size(), 0);
    print_verdict();
  end
endmodule
